/* inc/baap_pkg.sv */
// Package of constants shared by the bus attribute and parity ends
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package baap_pkg;

  // Transfer type codes, bits 0..3 with bit 0 as the msb
  localparam logic [3:0] TT_CLEAN = 4'h0;
  localparam logic [3:0] TT_WR_FLUSH = 4'h1;
  localparam logic [3:0] TT_FLUSH = 4'h2;
  localparam logic [3:0] TT_WR_KILL = 4'h3;
  localparam logic [3:0] TT_SYNC = 4'h4;
  localparam logic [3:0] TT_READ = 4'h5;
  localparam logic [3:0] TT_KILL = 4'h6;
  localparam logic [3:0] TT_RWITM = 4'h7;
  localparam logic [3:0] TT_RSVD_A = 4'h8;
  localparam logic [3:0] TT_WR_FLUSH_AT = 4'h9;
  localparam logic [3:0] TT_ECTL_OUT = 4'ha;
  localparam logic [3:0] TT_RSVD_B = 4'hb;
  localparam logic [3:0] TT_TLB_INV = 4'hc;
  localparam logic [3:0] TT_READ_AT = 4'hd;
  localparam logic [3:0] TT_ECTL_IN = 4'he;
  localparam logic [3:0] TT_RWITM_AT = 4'hf;

  // Bit positions inside the 5-bit type bus (index 4 = first bit)
  localparam int TT_SPECIAL_BIT = 4;
  localparam int TT_READ_BIT = 3;
  localparam int TT_INVAL_BIT = 2;
  localparam int TT_DATA_BIT = 1;
  localparam int TT_SPARE_BIT = 0;

  // Parity error timing, in bus clocks after the start strobe
  localparam int PERR_ASSERT_CYC = 2;
  localparam int PERR_RELEASE_CYC = 3;

  // Operation requests from the core side
  typedef enum logic [3:0] {
    BAAP_OP_CLEAN, BAAP_OP_FLUSH, BAAP_OP_SYNC, BAAP_OP_KILL,
    BAAP_OP_TLB_INV, BAAP_OP_WR_FLUSH, BAAP_OP_WR_KILL, BAAP_OP_READ,
    BAAP_OP_RWITM, BAAP_OP_WR_FLUSH_AT, BAAP_OP_READ_AT,
    BAAP_OP_RWITM_AT, BAAP_OP_ECTL_OUT, BAAP_OP_ECTL_IN
  } baap_op_t;

endpackage

/* inc/baap_if.sv */
// Shared address-tenure attribute and parity wires between both ends
`timescale 1ns/10ps
interface baap_if;
  logic transfer_start_n;
  logic ext_addr_transfer_start_n;
  logic global_snoop_n;
  logic [4:0] transfer_type;
  logic burst_indicator_n;
  logic [2:0] transfer_size;
  logic [31:0] addr;
  logic [3:0] addr_par;
  // Open-drain error wire: device side gives out and enable
  logic addr_parity_err_n_o;
  logic addr_parity_err_n_oe;
  logic addr_parity_err_n;

  // Pull-up resolution of the open-drain line
  assign addr_parity_err_n =
    (addr_parity_err_n_oe && !addr_parity_err_n_o) ? 1'b0 : 1'b1;

  modport dev (
    input transfer_start_n, ext_addr_transfer_start_n, global_snoop_n,
    input transfer_type, burst_indicator_n, transfer_size, addr, addr_par,
    output addr_parity_err_n_o, addr_parity_err_n_oe
  );
  modport far (
    output transfer_start_n, ext_addr_transfer_start_n, global_snoop_n,
    output transfer_type, burst_indicator_n, transfer_size, addr, addr_par,
    input addr_parity_err_n
  );
endinterface

/* hw/baap_dev.sv */
// Device end: type encoder, parity checker, extended code capture
`timescale 1ns/10ps
module baap_dev (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  baap_if.dev bus,
  // Core side request for an outgoing tenure
  input wire logic op_valid,
  input baap_pkg::baap_op_t op_kind,
  input wire logic op_burst,
  input wire logic [2:0] op_size,
  output logic [4:0] tt_out,
  output logic tt_is_data,
  output logic [7:0] ext_code_out,
  // Snoop side
  input wire logic is_master,
  input wire logic par_chk_en,
  output logic [7:0] ext_code_in,
  output logic ext_code_in_valid,
  output logic checkstop
);

  // ---------------------------------------------------------------
  // Outgoing transfer type encoding
  // ---------------------------------------------------------------
  // Per-kind code and tenure shape in one table. External control is the
  // odd pair: its code leaves the fourth bit clear yet a data tenure
  // still follows, so the data flag cannot be read off the code alone.
  logic [3:0] enc_tt;
  logic kind_data;
  always_comb begin
    enc_tt = baap_pkg::TT_SYNC;
    kind_data = 1'b0;
    case (op_kind)
      // Address-only broadcasts
      baap_pkg::BAAP_OP_CLEAN: begin
        enc_tt = baap_pkg::TT_CLEAN;
        kind_data = 1'b0;
      end
      baap_pkg::BAAP_OP_FLUSH: begin
        enc_tt = baap_pkg::TT_FLUSH;
        kind_data = 1'b0;
      end
      baap_pkg::BAAP_OP_SYNC: begin
        enc_tt = baap_pkg::TT_SYNC;
        kind_data = 1'b0;
      end
      baap_pkg::BAAP_OP_KILL: begin
        enc_tt = baap_pkg::TT_KILL;
        kind_data = 1'b0;
      end
      baap_pkg::BAAP_OP_TLB_INV: begin
        enc_tt = baap_pkg::TT_TLB_INV;
        kind_data = 1'b0;
      end
      // Plain data transfers
      baap_pkg::BAAP_OP_WR_FLUSH: begin
        enc_tt = baap_pkg::TT_WR_FLUSH;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_WR_KILL: begin
        enc_tt = baap_pkg::TT_WR_KILL;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_READ: begin
        enc_tt = baap_pkg::TT_READ;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_RWITM: begin
        enc_tt = baap_pkg::TT_RWITM;
        kind_data = 1'b1;
      end
      // Atomic data transfers, first bit set
      baap_pkg::BAAP_OP_WR_FLUSH_AT: begin
        enc_tt = baap_pkg::TT_WR_FLUSH_AT;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_READ_AT: begin
        enc_tt = baap_pkg::TT_READ_AT;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_RWITM_AT: begin
        enc_tt = baap_pkg::TT_RWITM_AT;
        kind_data = 1'b1;
      end
      // External control, single-beat data tenure despite its code
      baap_pkg::BAAP_OP_ECTL_OUT: begin
        enc_tt = baap_pkg::TT_ECTL_OUT;
        kind_data = 1'b1;
      end
      baap_pkg::BAAP_OP_ECTL_IN: begin
        enc_tt = baap_pkg::TT_ECTL_IN;
        kind_data = 1'b1;
      end
      // Unknown kinds fall back to sync so reserved codes never appear
      default: begin
        enc_tt = baap_pkg::TT_SYNC;
        kind_data = 1'b0;
      end
    endcase
  end

  // Registered outputs; spare bit tied low, held between requests
  logic [4:0] tt_ff;
  logic [7:0] xcode_out_ff;
  logic data_ff;
  wire [4:0] nxt_tt = {enc_tt, 1'b0};
  wire [7:0] nxt_xcode = {enc_tt, ~op_burst, op_size};
  wire nxt_data = kind_data;
  // Type register; the spare bit rides along as a constant zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tt_ff <= 5'h00;
    end else if (op_valid) begin
      tt_ff <= nxt_tt;
    end
  end
  // Extended code register, built from the same code as the type
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xcode_out_ff <= 8'h00;
    end else if (op_valid) begin
      xcode_out_ff <= nxt_xcode;
    end
  end
  // Data tenure flag for the core side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= 1'b0;
    end else if (op_valid) begin
      data_ff <= nxt_data;
    end
  end
  assign tt_out = tt_ff;
  assign ext_code_out = xcode_out_ff;
  assign tt_is_data = data_ff;

  // ---------------------------------------------------------------
  // Snooped extended code capture
  // ---------------------------------------------------------------
  // Active-high views of the two start strobes
  wire ext_start = !bus.ext_addr_transfer_start_n;
  wire mem_start = !bus.transfer_start_n;
  // The code rides on the type, burst and size wires of the first beat
  wire [7:0] xcode_in = {bus.transfer_type[4:1], bus.burst_indicator_n,
                         bus.transfer_size};
  logic [7:0] xcode_in_ff;
  logic xcode_vld_ff;
  // Only the extended start beat is looked at; second beat ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xcode_in_ff <= 8'h00;
      xcode_vld_ff <= 1'b0;
    end else begin
      xcode_vld_ff <= ext_start && !is_master;
      if (ext_start && !is_master) begin
        xcode_in_ff <= xcode_in;
      end
    end
  end
  assign ext_code_in = xcode_in_ff;
  assign ext_code_in_valid = xcode_vld_ff;

  // ---------------------------------------------------------------
  // Address parity check, odd parity per byte
  // ---------------------------------------------------------------
  logic [3:0] byte_bad;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_par
      // Byte 0 is the top address byte with parity bit 3
      assign byte_bad[gi] =
        ~^{bus.addr[31-8*gi -: 8], bus.addr_par[3-gi]};
    end
  endgenerate
  // Memory snoops need global; extended beat is always checked
  wire mem_snoop = mem_start && !bus.global_snoop_n;
  wire ext_snoop = ext_start;
  // A master does not check its own tenure
  wire snoop = !is_master && (mem_snoop || ext_snoop);
  wire par_err = snoop && (|byte_bad);

  // Stage pipe: error seen at start, drive at +2, release at +3.
  // A bad start in every cycle keeps the line low; each start still
  // owns exactly one slot, so the pulses never stretch or merge early.
  localparam int PIPE_LEN = baap_pkg::PERR_ASSERT_CYC;
  logic [PIPE_LEN-1:0] err_pipe_ff;
  logic chk_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_pipe_ff <= {PIPE_LEN{1'b0}};
    end else begin
      err_pipe_ff <= {err_pipe_ff[PIPE_LEN-2:0], par_err};
    end
  end
  // Sticky checkstop; only reset clears it, so there is no recovery
  // from an address parity fault short of a reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_ff <= 1'b0;
    end else if (err_pipe_ff[0] && par_chk_en) begin
      chk_ff <= 1'b1;
    end
  end
  // Driven low for one cycle, then open again
  assign bus.addr_parity_err_n_o = 1'b0;
  assign bus.addr_parity_err_n_oe = err_pipe_ff[PIPE_LEN-1];
  assign checkstop = chk_ff;

endmodule

/* hw/baap_far.sv */
// Far end: drives address tenures, decodes types, watches parity error
`timescale 1ns/10ps
module baap_far (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  baap_if.far bus,
  // User side tenure request
  input wire logic req_valid,
  input wire logic req_ext,
  input wire logic req_global,
  input wire logic [3:0] req_tt,
  input wire logic req_burst,
  input wire logic [2:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_par_flip,
  // Decoded and observed
  output logic data_bus_req,
  output logic snoop_invalidate,
  output logic type_reserved,
  output logic par_err_seen
);

  // ---------------------------------------------------------------
  // Drive start strobes, one strobe cycle per cycle of req_valid, with the tenure attributes
  // ---------------------------------------------------------------
  logic start_n_ff, ext_start_n_ff, global_n_ff, burst_n_ff;
  logic [4:0] tt_ff;
  logic [2:0] size_ff;
  logic [31:0] addr_ff;
  logic [3:0] par_ff;
  logic [3:0] good_par;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_par
      assign good_par[3-gi] = ~^req_addr[31-8*gi -: 8];
    end
  endgenerate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_n_ff <= 1'b1;
      ext_start_n_ff <= 1'b1;
      global_n_ff <= 1'b1;
      burst_n_ff <= 1'b1;
      tt_ff <= 5'h00;
      size_ff <= 3'h0;
      addr_ff <= 32'h0000_0000;
      par_ff <= 4'h0;
    end else begin
      // Strobes stay asserted for as long as req_valid is held and negate the cycle after it drops
      start_n_ff <= !(req_valid && !req_ext);
      ext_start_n_ff <= !(req_valid && req_ext);
      if (req_valid) begin
        global_n_ff <= !req_global;
        burst_n_ff <= !req_burst;
        tt_ff <= {req_tt, 1'b0};
        size_ff <= req_size;
        addr_ff <= req_addr;
        par_ff <= good_par ^ req_par_flip;
      end
    end
  end
  assign bus.transfer_start_n = start_n_ff;
  assign bus.ext_addr_transfer_start_n = ext_start_n_ff;
  assign bus.global_snoop_n = global_n_ff;
  assign bus.transfer_type = tt_ff;
  assign bus.burst_indicator_n = burst_n_ff;
  assign bus.transfer_size = size_ff;
  assign bus.addr = addr_ff;
  assign bus.addr_par = par_ff;

  // ---------------------------------------------------------------
  // Decode of the type seen on the bus, sampled at the start strobe
  // ---------------------------------------------------------------
  wire start = !bus.transfer_start_n || !bus.ext_addr_transfer_start_n;
  wire [3:0] tt = bus.transfer_type[4:1];
  wire ectl = (tt == baap_pkg::TT_ECTL_OUT) || (tt == baap_pkg::TT_ECTL_IN);
  // Decoded from the type code, plus global for invalidate; size and burst play no part in it
  wire nxt_dreq = start && (tt[0] || ectl);
  wire nxt_inv = start && !bus.global_snoop_n &&
                 bus.transfer_type[baap_pkg::TT_INVAL_BIT] && !ectl;
  wire nxt_rsvd = start && ((tt == baap_pkg::TT_RSVD_A) ||
                            (tt == baap_pkg::TT_RSVD_B));
  logic dreq_ff, inv_ff, rsvd_ff, pe_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_ff <= 1'b0;
      inv_ff <= 1'b0;
      rsvd_ff <= 1'b0;
      pe_ff <= 1'b0;
    end else begin
      dreq_ff <= nxt_dreq;
      inv_ff <= nxt_inv;
      rsvd_ff <= nxt_rsvd;
      pe_ff <= !bus.addr_parity_err_n;
    end
  end
  assign data_bus_req = dreq_ff;
  assign snoop_invalidate = inv_ff;
  assign type_reserved = rsvd_ff;
  assign par_err_seen = pe_ff;

endmodule

/* verif/baap_monitor.sv */
// Checker of parity error timing and extended start strobe shape on the bus
`timescale 1ns/10ps
module baap_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched bus wires
  input wire logic transfer_start_n,
  input wire logic ext_addr_transfer_start_n,
  input wire logic global_snoop_n,
  input wire logic [4:0] transfer_type,
  input wire logic [31:0] addr,
  input wire logic [3:0] addr_par,
  input wire logic addr_parity_err_n_o,
  input wire logic addr_parity_err_n_oe,
  input wire logic addr_parity_err_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------
  // Snoop qualification: a byte is good when its ones are odd
  // ----------------------------------------------------------
  wire logic [3:0] byte_odd = {^{addr[31:24], addr_par[3]},
    ^{addr[23:16], addr_par[2]}, ^{addr[15:8], addr_par[1]},
    ^{addr[7:0], addr_par[0]}};
  // Memory starts need global; extended starts are always checked
  wire logic snoop = (!transfer_start_n && !global_snoop_n) ||
    !ext_addr_transfer_start_n;
  wire logic bad_start = snoop && (byte_odd != 4'hf);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  err_on_time_a: assert property (bad_start |-> ##2 !addr_parity_err_n)
    else $error("parity error not flagged two cycles after start");
  err_cause_a: assert property (addr_parity_err_n_oe |-> $past(bad_start, 2))
    else $error("parity error without a bad snooped start");
  err_release_a: assert property ((bad_start ##1 !bad_start) |->
    ##1 addr_parity_err_n_oe ##1 !addr_parity_err_n_oe)
    else $error("parity error not released on the third cycle");
  drive_low_a: assert property (addr_parity_err_n_oe |-> !addr_parity_err_n_o)
    else $error("error pin driven high");
  quiet_idle_a: assert property ((transfer_start_n &&
    ext_addr_transfer_start_n)[*3] |-> addr_parity_err_n)
    else $error("error line low on an idle bus");
  good_quiet_a: assert property ((!bad_start)[*3] |-> !addr_parity_err_n_oe)
    else $error("error driven after good parity");
  ext_one_cyc_a: assert property ($fell(ext_addr_transfer_start_n) |=>
    ext_addr_transfer_start_n)
    else $error("extended start longer than one cycle");
  spare_low_a: assert property (!(transfer_start_n &&
    ext_addr_transfer_start_n) |-> !transfer_type[0])
    else $error("spare type bit high during a start");

  // Main scenarios reached
  cover property (bad_start && !transfer_start_n);
  cover property (bad_start && !ext_addr_transfer_start_n);
  cover property (!transfer_start_n && global_snoop_n && byte_odd != 4'hf);
endmodule

/* verif/bus_address_attribute_parity_unit_test.sv */
// Self-checking bench joining the device end and the far end
`timescale 1ns/10ps
module bus_address_attribute_parity_unit_test;
  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  logic sys_clk, rst_n, op_valid, op_burst, par_chk_en;
  baap_pkg::baap_op_t op_kind;
  logic [2:0] op_size, req_size;
  logic [4:0] tt_out;
  logic [7:0] ext_code_out, ext_code_in;
  logic tt_is_data, ext_code_in_valid, checkstop, is_master;
  logic req_valid, req_ext, req_global, req_burst;
  logic [3:0] req_tt, req_par_flip;
  logic [31:0] req_addr;
  logic data_bus_req, snoop_invalidate, type_reserved, par_err_seen;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  // Expected codes in the order of the request kinds
  logic [3:0] codes [14] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hc, 4'h1, 4'h3,
    4'h5, 4'h7, 4'h9, 4'hd, 4'hf, 4'ha, 4'he};
  baap_if bus ();

  baap_dev baap_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
    .op_valid(op_valid), .op_kind(op_kind), .op_burst(op_burst),
    .op_size(op_size), .tt_out(tt_out), .tt_is_data(tt_is_data),
    .ext_code_out(ext_code_out), .is_master(is_master),
    .par_chk_en(par_chk_en), .ext_code_in(ext_code_in),
    .ext_code_in_valid(ext_code_in_valid), .checkstop(checkstop));
  baap_far baap_far_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
    .req_valid(req_valid), .req_ext(req_ext), .req_global(req_global),
    .req_tt(req_tt), .req_burst(req_burst), .req_size(req_size),
    .req_addr(req_addr), .req_par_flip(req_par_flip),
    .data_bus_req(data_bus_req), .snoop_invalidate(snoop_invalidate),
    .type_reserved(type_reserved), .par_err_seen(par_err_seen));
  baap_monitor baap_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .transfer_start_n(bus.transfer_start_n),
    .ext_addr_transfer_start_n(bus.ext_addr_transfer_start_n),
    .global_snoop_n(bus.global_snoop_n),
    .transfer_type(bus.transfer_type), .addr(bus.addr),
    .addr_par(bus.addr_par), .addr_parity_err_n_o(bus.addr_parity_err_n_o),
    .addr_parity_err_n_oe(bus.addr_parity_err_n_oe),
    .addr_parity_err_n(bus.addr_parity_err_n));

  // ----------------------------------------------------------
  // Clock, hang guard and helpers
  // ----------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // The whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Inputs move 1 ns after the edge so no race with sampling
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  // One address tenure from the far end, checked through its walk
  task automatic tenure(input logic ext, glob, input logic [3:0] tt, flip);
    logic bad;
    bad = (flip != 4'h0) && (ext || glob) && !is_master;
    req_ext = ext;
    req_global = glob;
    req_tt = tt;
    req_par_flip = flip;
    req_burst = tt[3];
    req_size = tt[2:0];
    req_addr = {tt, 28'h5a3c96e};
    req_valid = 1'b1;
    step();
    req_valid = 1'b0;
    step();
    chk(type_reserved === (tt == 4'h8 || tt == 4'hb), "reserved");
    if (!ext) chk(snoop_invalidate === (tt[1] && glob), "inval");
    if (tt != 4'ha && tt != 4'he) chk(data_bus_req === tt[0], "dreq");
    // The capture flag stands only in the cycle after the start beat
    chk(ext_code_in_valid === (ext && !is_master), "ext valid");
    if (ext && !is_master)
      chk(ext_code_in === {tt, ~req_burst, req_size}, "xcode");
    step();
    chk(bus.addr_parity_err_n === !bad, "error assert");
    step();
    chk(bus.addr_parity_err_n === 1'b1, "error release");
    chk(par_err_seen === bad, "error seen");
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_kind = baap_pkg::BAAP_OP_CLEAN;
    op_burst = 1'b0;
    op_size = 3'h0;
    par_chk_en = 1'b0;
    is_master = 1'b0;
    req_valid = 1'b0;
    tenure_defaults();
    repeat (10) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    // Back-to-back requests through every kind
    op_valid = 1'b1;
    for (int i = 0; i < 14; i++) begin
      op_kind = baap_pkg::baap_op_t'(i);
      op_burst = i[0];
      op_size = 3'(i);
      step();
      chk(tt_out === {codes[i], 1'b0}, "type");
      chk(tt_out[4:1] !== 4'h8 && tt_out[4:1] !== 4'hb, "rsvd");
      chk(tt_is_data === (codes[i][0] || codes[i][3:1] == 3'h5 ||
        codes[i] == 4'he), "data tenure");
      chk(ext_code_out === {codes[i], ~op_burst, op_size}, "xc");
    end
    op_valid = 1'b0;
    $display("test encode done");
    tenure(1'b0, 1'b1, 4'h5, 4'h0);
    for (int b = 0; b < 4; b++) tenure(1'b0, 1'b1, 4'h7, 4'h1 << b);
    tenure(1'b0, 1'b0, 4'h3, 4'h2);
    tenure(1'b1, 1'b0, 4'ha, 4'h8);
    tenure(1'b1, 1'b1, 4'he, 4'h0);
    tenure(1'b0, 1'b1, 4'h8, 4'h0);
    tenure(1'b0, 1'b1, 4'hb, 4'h0);
    chk(checkstop === 1'b0, "checkstop while disabled");
    $display("test parity done");
    par_chk_en = 1'b1;
    tenure(1'b0, 1'b1, 4'h1, 4'h4);
    chk(checkstop === 1'b1, "checkstop");
    tenure(1'b0, 1'b1, 4'hd, 4'h0);
    chk(checkstop === 1'b1, "checkstop sticky");
    $display("test checkstop done");
    // While mastering, an extended start must not be captured
    is_master = 1'b1;
    tenure(1'b1, 1'b1, 4'he, 4'h0);
    is_master = 1'b0;
    $display("test master done");
    close_out();
  end
  task automatic tenure_defaults();
    req_ext = 1'b0;
    req_global = 1'b0;
    req_tt = 4'h4;
    req_burst = 1'b0;
    req_size = 3'h0;
    req_addr = 32'h0;
    req_par_flip = 4'h0;
  endtask
endmodule
